/* File: hdl/ebss_consts.svh */
`ifndef EBSS_CONSTS_SVH
`define EBSS_CONSTS_SVH

// Widths of the external address bus and of the period settings
`define EBSS_ADDR_W 20
`define EBSS_LEAD_W 2
`define EBSS_ACT_W 3
`define EBSS_TRAIL_W 2
`define EBSS_LANES_W 2

// Width of the timing-clock period counter
`define EBSS_CNT_W 5

// Extra timing cycle always added to the active period
`define EBSS_ACT_EXTRA 5'h01

// Level of the lowest address bit on an idle bus
`define EBSS_ADDR0_IDLE 1'b1

// Inactive level of every active-low strobe and of read/not-write
`define EBSS_STROBE_IDLE 1'b1
`define EBSS_RNW_IDLE 1'b1

// Minimum lead plus active cycles with asynchronous ready
`define EBSS_MIN_ASYNC_LA 5'h04

`endif

/* File: hdl/ebss_pkg.sv */
`default_nettype none
package ebss_pkg;
`include "ebss_consts.svh"

    // One set of lead, active and trail settings
    typedef struct packed {
        logic [`EBSS_LEAD_W-1:0] lead;
        logic [`EBSS_ACT_W-1:0] active;
        logic [`EBSS_TRAIL_W-1:0] trail;
    } ebss_period_t;

    // Zone timing configuration carried with each access
    typedef struct packed {
        ebss_period_t rd;
        ebss_period_t wr;
        logic period_double;
        logic ready_use;
        logic ready_async_select;
    } ebss_timing_t;

    // One access request
    typedef struct packed {
        logic write;
        logic [`EBSS_LANES_W-1:0] lanes;
        logic [`EBSS_ADDR_W-1:0] addr;
        ebss_timing_t timing;
    } ebss_req_t;

    // External memory port pins
    typedef struct packed {
        logic zone_select_n;
        logic read_strobe_n;
        logic write_enable_low_n;
        logic write_enable_high_n;
        logic read_not_write;
        logic [`EBSS_ADDR_W-1:0] external_address_bus;
    } ebss_pins_t;

    // Access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ALIGN,
        ST_LEAD,
        ST_ACTIVE,
        ST_TRAIL
    } ebss_state_t;

endpackage
`default_nettype wire

/* File: hdl/ebss_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ebss_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // Two-flop level synchroniser, first stage feeds only the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule // ebss_sync
`default_nettype wire

/* File: hdl/ebss_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none
module ebss_clkdiv (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic tim_half_i,
    input wire logic out_half_i,
    output logic step_o,
    output logic rise_o,
    output logic clk_out_o
);
    logic ph_reg;
    logic par_reg;
    logic out_reg;

    // Timing edge on every base edge, or every second one at half rate
    assign step_o = !tim_half_i || !ph_reg;
    // Output clock rises at this timing edge
    assign rise_o = step_o && (!out_half_i || par_reg);
    // Full-rate output follows the base clock directly
    assign clk_out_o = (!tim_half_i && !out_half_i) ? clk_i : out_reg;

    // Base phase and timing-cycle parity
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ph_reg <= 1'b0;
            par_reg <= 1'b0;
        end else begin
            ph_reg <= !ph_reg;
            if (step_o) begin
                par_reg <= !par_reg;
            end
        end
    end

    // Output clock level: high after each rising timing edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_reg <= 1'b0;
        end else if (out_half_i) begin
            if (step_o) begin
                out_reg <= par_reg;
            end
        end else begin
            out_reg <= step_o;
        end
    end
endmodule // ebss_clkdiv
`default_nettype wire

/* File: hdl/ebss_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ebss_consts.svh"
// How it works
// RL1 - Async ready: lead plus active at least four
// RL2 - Async ready: trail zero, lead/active minimums
// RL3 - Async one/one needs period doubling
// RL4 - Settings never checked, run as programmed
// RL5 - Four timing/output clock ratios supported
// RL6 - Periods counted in timing clock cycles
// RL7 - Strobes change only on timing edges
// RL8 - Output clock equals or halves timing clock
// RL9 - Equal clocks: strobes on output rising edge
// RL10 - Half clock: even count rising, odd falling
// RL11 - Select and write direction start rising edge
// RL12 - Strobe falls at active start, lead parity
// RL13 - Strobe rises at trail start, parity
// RL14 - Select released at end, total parity
// RL15 - Idle address held, bit zero high
// RL16 - Access starts on rising output edge
// RL17 - Alignment cycle drives all controls inactive
// RL18 - Upper write enable is address bit zero in 16-bit
// RL19 - Ready unused: input ignored, no waits
// RL20 - Access runs lead, active, trail phases
// RL21 - Period lengths from settings, doubling
// RL22 - Async ready when use and mode set
// RL23 - Select held low across whole access
module ebss_sequencer (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic link_clk_i,
    input wire logic cfg_tim_half_i,
    input wire logic cfg_out_half_i,
    input wire logic cfg_bus32_i,
    input wire ebss_pkg::ebss_req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    output logic done_o,
    input wire logic ext_ready_in_i,
    output ebss_pkg::ebss_pins_t pins_o,
    output logic interface_clock_out_o
);
    import ebss_pkg::*;

    // Length of one phase in timing cycles for a request
    function automatic logic [`EBSS_CNT_W-1:0] phase_len(input ebss_req_t r,
                                                         input ebss_state_t ph);
        ebss_period_t p;
        logic [`EBSS_CNT_W-1:0] len;
        p = r.write ? r.timing.wr : r.timing.rd;
        len = '0;
        case (ph)
            ST_LEAD: len = `EBSS_CNT_W'(p.lead) << r.timing.period_double;
            ST_ACTIVE: len = (`EBSS_CNT_W'(p.active) << r.timing.period_double)
                             + `EBSS_ACT_EXTRA;
            ST_TRAIL: len = `EBSS_CNT_W'(p.trail) << r.timing.period_double;
            default: len = '0;
        endcase
        return len;
    endfunction

    // ---------------- System clock side ----------------
    ebss_req_t hold_reg;
    logic busy_reg;
    logic req_tgl_reg;
    logic done_last_reg;
    logic done_s;
    logic done_tgl_reg;

    ebss_sync #(.W(1)) u_done_sync (
        .clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .d_i(done_tgl_reg),
        .q_o(done_s)
    );

    // Accept when idle; completion arrives as a toggle
    assign req_ready_o = !busy_reg;
    assign done_o = done_s ^ done_last_reg;

    // Request hold register, stable while the link side works
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_reg <= '0;
            req_tgl_reg <= 1'b0;
        end else if (req_valid_i && !busy_reg) begin
            hold_reg <= req_i;
            req_tgl_reg <= !req_tgl_reg;
        end
    end

    // Busy flag and completion edge tracking
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_reg <= 1'b0;
            done_last_reg <= 1'b0;
        end else begin
            done_last_reg <= done_s;
            if (req_valid_i && !busy_reg) begin
                busy_reg <= 1'b1;
            end else if (done_o) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // ---------------- Link clock side ----------------
    logic req_s;
    logic tim_half_s;
    logic out_half_s;
    logic bus32_s;
    logic ready_s;
    logic rdy_d_reg;
    logic req_ack_reg;
    logic step;
    logic rise;
    logic pending;
    logic ready_ok;
    logic start;
    logic finish;
    logic busy_next;
    ebss_state_t st_reg;
    ebss_state_t st_next;
    logic [`EBSS_CNT_W-1:0] cnt_reg;
    logic [`EBSS_CNT_W-1:0] cnt_next;
    logic ws_reg;
    logic ws_next;
    ebss_req_t cur_reg;
    ebss_req_t nr;
    logic [`EBSS_CNT_W-1:0] lead_seen_reg;

    ebss_sync #(.W(5)) u_link_sync (
        .clk_i(link_clk_i),
        .rstn_i(rstn_i),
        .d_i({req_tgl_reg, cfg_tim_half_i, cfg_out_half_i, cfg_bus32_i, ext_ready_in_i}),
        .q_o({req_s, tim_half_s, out_half_s, bus32_s, ready_s})
    );

    // RL5 RL8 clock ratios
    ebss_clkdiv u_clkdiv (
        .clk_i(link_clk_i),
        .rstn_i(rstn_i),
        .tim_half_i(tim_half_s),
        .out_half_i(out_half_s),
        .step_o(step),
        .rise_o(rise),
        .clk_out_o(interface_clock_out_o)
    );

    assign pending = req_s ^ req_ack_reg;
    // Request being started uses the fresh hold register
    assign nr = (st_reg == ST_IDLE || st_reg == ST_ALIGN) ? hold_reg : cur_reg;
    // RL19 RL22 ready source: ignored, direct, or one stage later
    assign ready_ok = !nr.timing.ready_use ||
                      (nr.timing.ready_async_select ? rdy_d_reg : ready_s);

    // Extra ready stage used in asynchronous mode
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdy_d_reg <= 1'b0;
        end else begin
            rdy_d_reg <= ready_s;
        end
    end

    // Next phase, evaluated for the coming timing edge
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        ws_next = ws_reg;
        start = 1'b0;
        finish = 1'b0;
        case (st_reg)
            ST_IDLE, ST_ALIGN: begin
                if (pending || st_reg == ST_ALIGN) begin
                    // RL16 start only where the output clock rises
                    if (rise) begin
                        start = 1'b1;
                        ws_next = 1'b0;
                        // RL4 RL20 zero lead is run as programmed
                        if (phase_len(nr, ST_LEAD) != '0) begin
                            st_next = ST_LEAD;
                            cnt_next = phase_len(nr, ST_LEAD) - `EBSS_CNT_W'(1);
                        end else begin
                            st_next = ST_ACTIVE;
                            cnt_next = phase_len(nr, ST_ACTIVE) - `EBSS_CNT_W'(1);
                        end
                    end else begin
                        st_next = ST_ALIGN;
                    end
                end
            end
            ST_LEAD: begin
                // RL6 RL21 count lead cycles
                if (cnt_reg == '0) begin
                    st_next = ST_ACTIVE;
                    cnt_next = phase_len(nr, ST_ACTIVE) - `EBSS_CNT_W'(1);
                end else begin
                    cnt_next = cnt_reg - `EBSS_CNT_W'(1);
                end
            end
            ST_ACTIVE: begin
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - `EBSS_CNT_W'(1);
                end else if (!ready_ok) begin
                    // RL19 hardware wait state only when ready is used
                    ws_next = 1'b1;
                end else if (phase_len(nr, ST_TRAIL) != '0) begin
                    st_next = ST_TRAIL;
                    cnt_next = phase_len(nr, ST_TRAIL) - `EBSS_CNT_W'(1);
                end else begin
                    st_next = ST_IDLE;
                    finish = 1'b1;
                end
            end
            ST_TRAIL: begin
                if (cnt_reg == '0) begin
                    st_next = ST_IDLE;
                    finish = 1'b1;
                end else begin
                    cnt_next = cnt_reg - `EBSS_CNT_W'(1);
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    assign busy_next = (st_next == ST_LEAD) || (st_next == ST_ACTIVE) ||
                       (st_next == ST_TRAIL);

    // State, counter and handshake toggles advance on timing edges
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= ST_IDLE;
            cnt_reg <= '0;
            ws_reg <= 1'b0;
            cur_reg <= '0;
            req_ack_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end else if (step) begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            ws_reg <= ws_next;
            if (start) begin
                cur_reg <= hold_reg;
                if (pending) begin
                    req_ack_reg <= !req_ack_reg;
                end
            end
            if (finish) begin
                done_tgl_reg <= !done_tgl_reg;
            end
        end
    end

    // RL7 RL9 RL10 pins update only on timing edges
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_o.zone_select_n <= `EBSS_STROBE_IDLE;
            pins_o.read_strobe_n <= `EBSS_STROBE_IDLE;
            pins_o.write_enable_low_n <= `EBSS_STROBE_IDLE;
            pins_o.write_enable_high_n <= `EBSS_ADDR0_IDLE;
            pins_o.external_address_bus <= {{(`EBSS_ADDR_W-1){1'b0}}, `EBSS_ADDR0_IDLE};
            pins_o.read_not_write <= `EBSS_RNW_IDLE;
        end else if (step) begin
            // RL11 RL14 RL17 RL23 select and direction span the access
            pins_o.zone_select_n <= !busy_next;
            pins_o.read_not_write <= !(busy_next && nr.write);
            // RL12 RL13 strobes low only in the active phase
            pins_o.read_strobe_n <= !(st_next == ST_ACTIVE && !nr.write);
            pins_o.write_enable_low_n <= !(st_next == ST_ACTIVE && nr.write &&
                                           nr.lanes[0]);
            // RL15 address held when idle, bit zero high
            if (busy_next) begin
                pins_o.external_address_bus <= nr.addr;
            end else begin
                pins_o.external_address_bus[0] <= `EBSS_ADDR0_IDLE;
            end
            // RL18 upper enable carries address bit zero in 16-bit mode
            if (bus32_s) begin
                pins_o.write_enable_high_n <= !(st_next == ST_ACTIVE && nr.write &&
                                                nr.lanes[1]);
            end else begin
                pins_o.write_enable_high_n <= busy_next ? nr.addr[0] : `EBSS_ADDR0_IDLE;
            end
        end
    end

    // Lead cycle counter watched by the lead length check below
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lead_seen_reg <= '0;
        end else if (step) begin
            if (st_reg == ST_LEAD) begin
                lead_seen_reg <= lead_seen_reg + `EBSS_CNT_W'(1);
            end else begin
                lead_seen_reg <= '0;
            end
        end
    end

    // RL23 select stays low through the access
    cs_hold_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL23
        (st_reg == ST_LEAD || st_reg == ST_ACTIVE || st_reg == ST_TRAIL)
        |-> !pins_o.zone_select_n)
        else $error("select released inside an access");

    // RL17 alignment keeps controls inactive
    align_idle_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL17
        st_reg == ST_ALIGN |-> pins_o.zone_select_n && pins_o.read_strobe_n &&
        pins_o.write_enable_low_n && pins_o.read_not_write)
        else $error("control active during alignment");

    // RL7 strobes move only after a timing edge
    strobe_step_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL7
        ($changed(pins_o.read_strobe_n) || $changed(pins_o.zone_select_n))
        |-> $past(step))
        else $error("strobe changed off a timing edge");

    // RL16 access opens on a rising output edge
    start_rise_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL16
        $fell(pins_o.zone_select_n) |-> $past(rise))
        else $error("access started off a rising output edge");

    // RL19 no wait states when ready unused
    ready_ignore_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL19
        st_reg == ST_ACTIVE && cnt_reg == '0 && !nr.timing.ready_use
        |-> !ws_reg && st_next != ST_ACTIVE)
        else $error("wait state with ready unused");

    // RL21 lead length matches setting
    lead_len_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL21
        step && st_reg == ST_LEAD && st_next != ST_LEAD
        |-> lead_seen_reg + `EBSS_CNT_W'(1) == phase_len(nr, ST_LEAD))
        else $error("lead period length wrong");

    // RL15 idle address bit zero high
    addr_idle_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL15
        st_reg == ST_IDLE |-> pins_o.external_address_bus[0])
        else $error("address bit zero low while idle");

    // RL11 write direction with select
    rnw_write_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL11
        !pins_o.zone_select_n && cur_reg.write && st_reg != ST_IDLE
        |-> !pins_o.read_not_write)
        else $error("read/not-write high during write");

    // RL18 16-bit mode upper enable mirrors address bit zero
    we_hi_addr_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i) // RL18
        !bus32_s && $stable(bus32_s) && !step
        |-> pins_o.write_enable_high_n == pins_o.external_address_bus[0])
        else $error("upper enable not carrying address bit zero");
endmodule // ebss_sequencer
`default_nettype wire

/* File: test/ebss_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebss_mem_model (
    input wire logic link_clk_i,
    input wire logic rstn_i,
    input wire ebss_pkg::ebss_pins_t pins_i,
    input wire logic [7:0] wait_i,
    output logic ready_o
);
    import ebss_pkg::*;

    logic [7:0] busy_reg;
    logic sel_on;

    // Busy from select fall, early enough for the sequencer's ready stages
    assign sel_on = !pins_i.zone_select_n;

    // Link cycles spent since select fell
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_reg <= 8'h00;
        end else if (!sel_on) begin
            busy_reg <= 8'h00;
        end else if (busy_reg != 8'hff) begin
            busy_reg <= busy_reg + 8'h01;
        end
    end

    // Ready held low while the memory still works
    assign ready_o = !(sel_on && (busy_reg < wait_i));
endmodule // ebss_mem_model
`default_nettype wire

/* File: test/tb_ext_bus_strobe_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ext_bus_strobe_sequencer;
    import ebss_pkg::*;

    logic sys_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic tim_half = 1'b0;
    logic out_half = 1'b0;
    logic bus32 = 1'b1;
    ebss_req_t req = '0;
    logic req_valid = 1'b0;
    logic req_ready;
    logic done;
    logic ready;
    ebss_pins_t pins;
    logic clk_out;
    logic [7:0] wait_cyc = 8'h00;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int lead_n = 0;
    int act_n = 0;
    int trail_n = 0;
    int cnt = 0;
    int div = 1;
    logic sel_q = 1'b1;
    logic stb_q = 1'b1;
    logic stb;
    logic seen_act = 1'b0;
    logic cur_write = 1'b0;
    logic [1:0] cur_lanes = 2'h0;
    logic [19:0] cur_addr = 20'h00000;
    logic [19:0] mon_addr = 20'h00000;

    ebss_sequencer i_ebss_sequencer (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .link_clk_i(link_clk_i),
        .cfg_tim_half_i(tim_half),
        .cfg_out_half_i(out_half),
        .cfg_bus32_i(bus32),
        .req_i(req),
        .req_valid_i(req_valid),
        .req_ready_o(req_ready),
        .done_o(done),
        .ext_ready_in_i(ready),
        .pins_o(pins),
        .interface_clock_out_o(clk_out)
    );

    ebss_mem_model i_ebss_mem_model (
        .link_clk_i(link_clk_i),
        .rstn_i(rstn_i),
        .pins_i(pins),
        .wait_i(wait_cyc),
        .ready_o(ready)
    );

    // Clocks of both domains
    always #25 sys_clk_i = ~sys_clk_i;
    always #62.5 link_clk_i = ~link_clk_i;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Strobe change at k link cycles from start
    task automatic edge_chk(input int k);
        chk("edge_div", k % div, 0);
        chk("edge_clk", clk_out, out_half ? ((k / div) % 2 == 0) : 1);
    endtask

    // Pin monitor just after each link edge
    always @(posedge link_clk_i) begin
        #1;
        if (rstn_i === 1'b1 && pins.zone_select_n === 1'b0) begin
            stb = cur_write ? pins.write_enable_low_n : pins.read_strobe_n;
            if (sel_q !== 1'b0) begin
                cnt = 0;
                lead_n = 0;
                act_n = 0;
                trail_n = 0;
                seen_act = 1'b0;
                mon_addr = cur_addr;
                chk("start_clk", clk_out, 1'b1);
            end else begin
                cnt++;
            end
            chk("rnw", pins.read_not_write, !cur_write);
            chk("addr", pins.external_address_bus, cur_addr);
            if (stb === 1'b0) begin
                act_n++;
                seen_act = 1'b1;
                chk("upper_we", pins.write_enable_high_n,
                    !bus32 ? cur_addr[0] : (cur_write ? !cur_lanes[1] : 1'b1));
            end else if (seen_act) begin
                trail_n++;
            end else begin
                lead_n++;
            end
            if (stb !== stb_q) begin
                edge_chk(cnt);
            end
        end else if (rstn_i === 1'b1) begin
            stb = 1'b1;
            if (sel_q === 1'b0) begin
                edge_chk(cnt + 1);
            end
            chk("idle_ctl", {pins.read_strobe_n, pins.write_enable_low_n, pins.write_enable_high_n,
                pins.read_not_write, pins.external_address_bus[0]}, 5'h1f);
            chk("idle_addr", pins.external_address_bus[19:1], mon_addr[19:1]);
        end
        sel_q = pins.zone_select_n;
        stb_q = stb;
    end

    // Hang guard
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            $display("timeout");
            test_done();
        end
    end

    task automatic set_mode(input logic t, input logic o, input logic b);
        @(negedge sys_clk_i);
        tim_half = t;
        out_half = o;
        bus32 = b;
        div = t ? 2 : 1;
        repeat (20) @(negedge sys_clk_i);
    endtask

    task automatic access(input string name, input logic wr, input logic [1:0] ln,
        input logic [19:0] ad, input int ld, input int ac, input int tr, input logic dbl,
        input logic ru, input logic ram, input logic [7:0] w);
        int k;
        int nl;
        int na;
        int nt;
        nl = (ld << dbl) * div;
        na = ((ac << dbl) + 1) * div;
        nt = (tr << dbl) * div;
        @(negedge sys_clk_i);
        cur_write = wr;
        cur_lanes = ln;
        cur_addr = ad;
        wait_cyc = w;
        req = {wr, ln, ad, ld[1:0], ac[2:0], tr[1:0], ld[1:0], ac[2:0], tr[1:0], dbl, ru, ram};
        chk("ready_idle", req_ready, 1'b1);
        req_valid = 1'b1;
        @(negedge sys_clk_i);
        req_valid = 1'b0;
        chk("ready_busy", req_ready, 1'b0);
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            @(negedge sys_clk_i);
            k++;
        end
        chk("done_seen", done, 1'b1);
        @(negedge sys_clk_i);
        chk("done_pulse", {done, req_ready}, 2'b01);
        chk("lead_len", lead_n, nl);
        chk("trail_len", trail_n, nt);
        if (ru && w != 8'h00) begin
            chk("act_waits", (act_n > na) && (act_n <= na + w + 8 * div), 1'b1);
        end else begin
            chk("act_len", act_n, na);
        end
        $display("test %s done", name);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(negedge link_clk_i);
        @(negedge sys_clk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        for (int m = 0; m < 4; m++) begin
            // Four timing and output clock ratios
            set_mode(m[1], m[0], 1'b1);
            access("rd_min", 1'b0, 2'h1, 20'ha5a5b, 1, 0, 0, 1'b0, 1'b0, 1'b0, 8'h00);
            access("wr_both", 1'b1, 2'h3, 20'h5a5a4, 2, 1, 1, 1'b0, 1'b0, 1'b0, 8'h00);
        end
        set_mode(1'b0, 1'b1, 1'b1);
        access("rd_odd_lead", 1'b0, 2'h1, 20'h12345, 1, 2, 1, 1'b0, 1'b0, 1'b0, 8'h00);
        access("wr_double", 1'b1, 2'h1, 20'h0fff0, 1, 1, 2, 1'b1, 1'b0, 1'b0, 8'h00);
        access("zero_lead", 1'b0, 2'h1, 20'h00002, 0, 0, 0, 1'b0, 1'b0, 1'b0, 8'h00);
        access("ready_off", 1'b0, 2'h1, 20'h33333, 1, 1, 0, 1'b0, 1'b0, 1'b0, 8'h14);
        access("sync_wait", 1'b0, 2'h1, 20'h44444, 1, 1, 0, 1'b0, 1'b1, 1'b0, 8'h14);
        // Asynchronous ready with legal settings only
        access("async_12", 1'b0, 2'h1, 20'h55555, 1, 2, 0, 1'b0, 1'b1, 1'b1, 8'h00);
        access("async_21", 1'b1, 2'h3, 20'h66666, 2, 1, 0, 1'b0, 1'b1, 1'b1, 8'h14);
        access("async_dbl", 1'b0, 2'h1, 20'h77777, 1, 1, 0, 1'b1, 1'b1, 1'b1, 8'h00);
        set_mode(1'b1, 1'b1, 1'b0);
        access("wr_16", 1'b1, 2'h1, 20'h8888a, 1, 1, 1, 1'b0, 1'b0, 1'b0, 8'h00);
        access("rd_16", 1'b0, 2'h1, 20'h99999, 2, 0, 1, 1'b0, 1'b0, 1'b0, 8'h00);
        test_done();
    end
endmodule // tb_ext_bus_strobe_sequencer
`default_nettype wire
